// >>> core/lss_core.sv
// line sensing status and control: aux converter samples, detectors, registers
// assumes 8-bit signed converter samples with a valid strobe, and an analog hook path
// Overview of operation
// - 8-bit aux converter samples ring sense pins
// - large ring-sense swing raises wake and status
// - loop voltage sample flags line in use
// - offhook voltage drop flags parallel pickup
// - polarity reversal detected only while on-hook
// - offhook caller ID uses normal receive path
// - over-voltage or over-current forces on-hook
// - under-voltage in line power selects barrier power
// - per-function enables gated by master enable
// - under-voltage status is an interrupt source
// - over-voltage threshold selectable 60 or 70
// - AC overload indicator above peak level
// - over-current flagged, on-hook if enabled
// - write-only receive boost, default zero
// - caller ID mode routes ring sense to filter
// - two-bit ring threshold selects detect level
// - threshold zero disables ring detection
// - ring status latched, cleared on read, maskable
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "lss_defines.svh"
module lss_core (
	// clock, reset, enable
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_ce,
	// register port
	input wire lss_pkg::lss_bus_t i_bus,
	output logic [`LSS_DW-1:0] o_rdata,
	// converter and line inputs
	input wire lss_pkg::lss_sense_t i_sense,
	input wire logic i_hook_request,
	// line side controls
	output logic o_offhook,
	output logic o_barrier_power,
	output logic o_wake,
	output logic o_rx_boost,
	output logic o_cid_mode,
	output logic o_rx_normal_path,
	// interrupt
	output logic o_irq
);
	function automatic logic [7:0] mag(input logic [7:0] s);
		mag = s[7] ? ~s : s;
	endfunction
	function automatic logic hit(input logic [7:0] a, input logic [7:0] a_r);
		hit = (a & ~a_r) != 8'h00;
	endfunction

	logic [1:0] ring_threshold_select_r;
	logic receive_gain_boost_r, caller_id_path_mode_r, normal_r;
	logic [7:0] den_r;
	logic [`LSS_NEV-1:0] stat_r, ien_r;
	logic [7:0] ring_r, loop_r;
	logic ring_above_r, pol_r, pol_valid_r;
	logic hook_r, barrier_r, wake_r, irq_r;
	logic [7:0] rdata_r;

	wire bus_wr = i_ce & i_bus.wr;
	wire bus_rd = i_ce & i_bus.rd;
	wire [7:0] adr = i_bus.addr;
	wire wr_ring_threshold_select = bus_wr & (adr == `LSS_ADR_RING_THRESHOLD_SELECT);
	wire wr_rx = bus_wr & (adr == `LSS_ADR_RXCTL);
	wire wr_cid = bus_wr & (adr == `LSS_ADR_CIDCTL);
	wire wr_den = bus_wr & (adr == `LSS_ADR_DETEN);
	wire wr_ien = bus_wr & (adr == `LSS_ADR_IEN);
	wire master = den_r[`LSS_DEN_MASTER];
	wire [7:0] ring_mag = mag(i_sense.ring_sample);
	wire [7:0] loop_mag = mag(i_sense.loop_sample);
	wire [7:0] ring_th = (ring_threshold_select_r == 2'h1) ? `LSS_RTH1 :
		(ring_threshold_select_r == 2'h2) ? `LSS_RTH2 : `LSS_RTH3;
	wire ring_en = ring_threshold_select_r != 2'h0;
	wire smp = i_sense.sample_valid;
	wire ring_above = smp & ring_en & (ring_mag > ring_th);
	wire ring_rise = ring_above & ~ring_above_r;
	wire pol_now = i_sense.loop_sample[7];
	wire rev_ev = smp & ring_en & ~hook_r & pol_valid_r & (pol_now != pol_r) &
		(loop_mag > ring_th);
	wire ring_ev = ring_rise | rev_ev;
	wire [7:0] ov_th = den_r[`LSS_DEN_OVSEL] ? `LSS_OV70 : `LSS_OV60;
	wire ov_ev = master & den_r[`LSS_DEN_OV] & smp & (loop_mag > ov_th);
	wire oc_ev = master & den_r[`LSS_DEN_OC] & i_sense.overcurrent;
	wire uv_ev = master & den_r[`LSS_DEN_UV] & smp & hook_r & (loop_mag < `LSS_UV_MIN);
	wire acol_ev = master & i_sense.ac_overload;
	wire liu_ev = master & den_r[`LSS_DEN_LIU] & smp & ~hook_r &
		(loop_mag < `LSS_LIU_MIN);
	wire ppu_ev = master & den_r[`LSS_DEN_PPU] & smp & hook_r & (loop_r > loop_mag) &
		((loop_r - loop_mag) > `LSS_PPU_DROP);
	wire trip = ov_ev | oc_ev;
	wire [`LSS_NEV-1:0] ev;
	assign ev[`LSS_ST_RING] = ring_ev;
	assign ev[`LSS_ST_UV] = uv_ev;
	assign ev[`LSS_ST_OV] = ov_ev;
	assign ev[`LSS_ST_OC] = oc_ev;
	assign ev[`LSS_ST_ACOL] = acol_ev;
	assign ev[`LSS_ST_PPU] = ppu_ev;
	assign ev[`LSS_ST_LIU] = liu_ev;
	wire rd_stat = bus_rd & (adr == `LSS_ADR_STAT);
	wire wr_clr = bus_wr & (adr == `LSS_ADR_ICLR);
	wire [`LSS_NEV-1:0] clr = (wr_clr ? i_bus.wdata[`LSS_NEV-1:0] : 7'h00) |
		(rd_stat ? 7'h01 : 7'h00);
	wire [`LSS_NEV-1:0] stat_nxt = (stat_r & ~clr) | (i_ce ? ev : 7'h00);
	wire [`LSS_NEV-1:0] ien_nxt = wr_ien ? i_bus.wdata[`LSS_NEV-1:0] : ien_r;
	wire hook_nxt = trip ? 1'b0 : i_hook_request;
	wire [7:0] rd_mux =
		(adr == `LSS_ADR_RING_THRESHOLD_SELECT) ? {6'h00, ring_threshold_select_r} :
		(adr == `LSS_ADR_CIDCTL) ? {3'h0, caller_id_path_mode_r, 4'h0} :
		(adr == `LSS_ADR_DETEN) ? den_r :
		(adr == `LSS_ADR_STAT) ? {1'b0, stat_r} :
		(adr == `LSS_ADR_IEN) ? {1'b0, ien_r} :
		(adr == `LSS_ADR_LIVE) ? {5'h00, barrier_r, wake_r, hook_r} :
		(adr == `LSS_ADR_RING) ? ring_r :
		(adr == `LSS_ADR_LOOP) ? loop_r : 8'h00;

	// host control registers, one short block each
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ring_threshold_select_r <= 2'h0;
		end else if (wr_ring_threshold_select) begin
			ring_threshold_select_r <= i_bus.wdata[1:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			receive_gain_boost_r <= 1'b0;
		end else if (wr_rx) begin
			receive_gain_boost_r <= i_bus.wdata[`LSS_BIT_RECEIVE_GAIN_BOOST];
		end
	end

	// normal path is registered so the output leaves a flip-flop
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			caller_id_path_mode_r <= 1'b0;
			normal_r <= 1'b1;
		end else if (wr_cid) begin
			caller_id_path_mode_r <= i_bus.wdata[`LSS_BIT_CALLER_ID_PATH_MODE];
			normal_r <= ~i_bus.wdata[`LSS_BIT_CALLER_ID_PATH_MODE];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			den_r <= 8'h00;
		end else if (wr_den) begin
			den_r <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ien_r <= `LSS_IEN_RST;
		end else if (wr_ien) begin
			ien_r <= ien_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			stat_r <= 7'h00;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else if (i_ce) begin
			stat_r <= stat_nxt;
			irq_r <= (stat_nxt & ien_nxt) != 7'h00;
			rdata_r <= bus_rd ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ring_r <= 8'h00;
			loop_r <= 8'h00;
			ring_above_r <= 1'b0;
			pol_r <= 1'b0;
			pol_valid_r <= 1'b0;
			wake_r <= 1'b0;
		end else if (i_ce && smp) begin
			ring_r <= i_sense.ring_sample;
			loop_r <= loop_mag;
			ring_above_r <= ring_above;
			pol_r <= pol_now;
			pol_valid_r <= 1'b1;
			wake_r <= ring_ev;
		end else if (i_ce) begin
			wake_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			hook_r <= 1'b0;
			barrier_r <= 1'b0;
		end else if (i_ce) begin
			hook_r <= hook_nxt;
			if (uv_ev && den_r[`LSS_DEN_LINEPWR]) barrier_r <= 1'b1;
			else if (!den_r[`LSS_DEN_LINEPWR]) barrier_r <= 1'b0;
		end
	end

	assign o_rdata = rdata_r;
	assign o_offhook = hook_r;
	assign o_barrier_power = barrier_r;
	assign o_wake = wake_r;
	assign o_rx_boost = receive_gain_boost_r;
	assign o_cid_mode = caller_id_path_mode_r;
	assign o_rx_normal_path = normal_r;
	assign o_irq = irq_r;

	// checks
	ring_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && ring_ev |=> stat_r[`LSS_ST_RING]) else $error("ring event not latched");
	ring_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
		ring_threshold_select_r == 2'h0 |-> !ring_ev) else $error("ring detected with zero threshold");
	trip_hook_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && trip |=> !o_offhook) else $error("no auto on-hook on trip");
	trip_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
		trip |-> master) else $error("trip without master enable");
	uv_barrier_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && uv_ev && den_r[`LSS_DEN_LINEPWR] |=> o_barrier_power)
		else $error("no barrier power on undervoltage");
	rev_onhook_a: assert property (@(posedge i_clock) disable iff (i_rst)
		rev_ev |-> !o_offhook) else $error("reversal while offhook");
	irq_level_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce |=> o_irq == ((stat_r & ien_r) != 7'h00)) else $error("irq mismatch");
	ring_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && rd_stat && !ring_ev |=> !stat_r[`LSS_ST_RING]) else $error("read clear lost");
	cid_path_a: assert property (@(posedge i_clock) disable iff (i_rst)
		o_cid_mode |-> !o_rx_normal_path) else $error("normal path left on");
	// register writes
	boost_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && wr_rx |=> o_rx_boost == $past(i_bus.wdata[`LSS_BIT_RECEIVE_GAIN_BOOST]))
		else $error("boost write lost");
	boost_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !wr_rx |=> $stable(o_rx_boost))
		else $error("boost changed without write");
	cid_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && wr_cid |=> o_cid_mode == $past(i_bus.wdata[`LSS_BIT_CALLER_ID_PATH_MODE]))
		else $error("caller id mode write lost");
	cid_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !wr_cid |=> $stable(o_cid_mode))
		else $error("caller id mode changed without write");
	normal_path_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!o_cid_mode |-> o_rx_normal_path)
		else $error("normal path cut outside caller id mode");
	ring_threshold_select_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && wr_ring_threshold_select |=> ring_threshold_select_r == $past(i_bus.wdata[1:0]))
		else $error("ring threshold write lost");
	ring_threshold_select_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !wr_ring_threshold_select |=> $stable(ring_threshold_select_r))
		else $error("ring threshold changed without write");
	den_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && wr_den |=> den_r == $past(i_bus.wdata))
		else $error("detect enable write lost");
	ien_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && wr_ien |=> ien_r == $past(i_bus.wdata[`LSS_NEV-1:0]))
		else $error("irq enable write lost");
	rdata_idle_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !bus_rd |=> o_rdata == 8'h00)
		else $error("read data outside read slot");
	freeze_state_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_ce |=> $stable(stat_r) && $stable(o_offhook) && $stable(den_r))
		else $error("state moved with enable low");

	// sampling and ring detection
	ring_sample_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && smp |=> ring_r == $past(i_sense.ring_sample))
		else $error("ring sample not kept");
	loop_sample_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && smp |=> loop_r == $past(loop_mag))
		else $error("loop sample not kept");
	wake_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && smp && ring_ev |=> o_wake)
		else $error("wake missing after ring event");
	wake_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !smp |=> !o_wake)
		else $error("wake without sample");
	rev_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && rev_ev |=> stat_r[`LSS_ST_RING])
		else $error("reversal not latched");
	pol_track_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && smp |=> pol_valid_r)
		else $error("polarity reference not armed");
	ring_sticky_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !rd_stat && stat_r[`LSS_ST_RING] |=> stat_r[`LSS_ST_RING])
		else $error("ring status dropped without read");
	set_wins_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && rd_stat && ring_ev |=> stat_r[`LSS_ST_RING])
		else $error("read clear beat new ring event");
	irq_mask_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && ien_nxt == 7'h00 |=> !o_irq)
		else $error("irq raised while fully masked");

	// protection detectors
	master_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
		!master |-> ev[`LSS_ST_LIU:`LSS_ST_UV] == 6'h00)
		else $error("detector active without master enable");
	ov_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && ov_ev |=> stat_r[`LSS_ST_OV])
		else $error("over-voltage not latched");
	ov_sel_a: assert property (@(posedge i_clock) disable iff (i_rst)
		den_r[`LSS_DEN_OVSEL] && loop_mag <= `LSS_OV70 |-> !ov_ev)
		else $error("over-voltage below selected level");
	oc_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && oc_ev |=> stat_r[`LSS_ST_OC])
		else $error("over-current not latched");
	trip_stat_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && trip |=> stat_r[`LSS_ST_OV] || stat_r[`LSS_ST_OC])
		else $error("trip without status");
	hook_follow_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !trip |=> o_offhook == $past(i_hook_request))
		else $error("hook not following request");
	acol_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && acol_ev |=> stat_r[`LSS_ST_ACOL])
		else $error("ac overload not latched");
	uv_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && uv_ev |=> stat_r[`LSS_ST_UV])
		else $error("under-voltage not latched");
	uv_offhook_a: assert property (@(posedge i_clock) disable iff (i_rst)
		uv_ev |-> o_offhook)
		else $error("under-voltage while onhook");
	barrier_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && o_barrier_power && den_r[`LSS_DEN_LINEPWR] |=> o_barrier_power)
		else $error("barrier power dropped early");
	barrier_drop_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && !den_r[`LSS_DEN_LINEPWR] |=> !o_barrier_power)
		else $error("barrier power without line power mode");
	liu_onhook_a: assert property (@(posedge i_clock) disable iff (i_rst)
		liu_ev |-> !o_offhook)
		else $error("line in use flagged offhook");
	liu_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && liu_ev |=> stat_r[`LSS_ST_LIU])
		else $error("line in use not latched");
	ppu_offhook_a: assert property (@(posedge i_clock) disable iff (i_rst)
		ppu_ev |-> o_offhook)
		else $error("parallel pickup flagged onhook");
	ppu_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		i_ce && ppu_ev |=> stat_r[`LSS_ST_PPU])
		else $error("parallel pickup not latched");

	ov_cov: cover property (@(posedge i_clock) disable iff (i_rst) ov_ev && o_offhook);
	ring_cov: cover property (@(posedge i_clock) disable iff (i_rst) ring_rise ##[1:20] o_irq);
	ppu_cov: cover property (@(posedge i_clock) disable iff (i_rst) ppu_ev);
	rev_cov: cover property (@(posedge i_clock) disable iff (i_rst) rev_ev);
endmodule

// >>> core/lss_defines.svh
// constants for the line sensing status and control block
// assumes inclusion by bare name from the block package and design file
`ifndef LSS_DEFINES_SVH
`define LSS_DEFINES_SVH
`define LSS_AW 8
`define LSS_DW 8
`define LSS_ADR_RING_THRESHOLD_SELECT 8'h0E
`define LSS_ADR_RXCTL 8'h14
`define LSS_ADR_CIDCTL 8'h15
`define LSS_ADR_DETEN 8'h30
`define LSS_ADR_STAT 8'h31
`define LSS_ADR_IEN 8'h32
`define LSS_ADR_ICLR 8'h33
`define LSS_ADR_LIVE 8'h34
`define LSS_ADR_RING 8'h35
`define LSS_ADR_LOOP 8'h36
`define LSS_BIT_RECEIVE_GAIN_BOOST 3
`define LSS_BIT_CALLER_ID_PATH_MODE 4
`define LSS_DEN_MASTER 0
`define LSS_DEN_UV 1
`define LSS_DEN_OV 2
`define LSS_DEN_OC 3
`define LSS_DEN_OVSEL 4
`define LSS_DEN_LINEPWR 5
`define LSS_DEN_LIU 6
`define LSS_DEN_PPU 7
`define LSS_ST_RING 0
`define LSS_ST_UV 1
`define LSS_ST_OV 2
`define LSS_ST_OC 3
`define LSS_ST_ACOL 4
`define LSS_ST_PPU 5
`define LSS_ST_LIU 6
`define LSS_NEV 7
`define LSS_RTH1 8'h0F
`define LSS_RTH2 8'h1E
`define LSS_RTH3 8'h2D
`define LSS_OV60 8'h3C
`define LSS_OV70 8'h46
`define LSS_LIU_MIN 8'h10
`define LSS_UV_MIN 8'h08
`define LSS_PPU_DROP 8'h04
`define LSS_IEN_RST 7'h01
`endif

// >>> core/lss_pkg.sv
// types shared by the line sensing status and control block
// assumes lss_defines.svh is compiled alongside
`include "lss_defines.svh"
package lss_pkg;
	typedef struct packed {
		logic [`LSS_AW-1:0] addr;
		logic [`LSS_DW-1:0] wdata;
		logic wr;
		logic rd;
	} lss_bus_t;
	typedef struct packed {
		logic [`LSS_DW-1:0] ring_sample;
		logic [`LSS_DW-1:0] loop_sample;
		logic sample_valid;
		logic ac_overload;
		logic overcurrent;
		logic offhook;
	} lss_sense_t;
	typedef enum logic [1:0] {LSS_ONHOOK, LSS_OFFHOOK, LSS_TRIPPED} lss_hook_t;
endpackage

// >>> verif/lss_line_model.sv
// line-side model: aux converter samples and analog comparators
// assumes the bench asks for one sample per fire pulse
`timescale 1ns/1ps
module lss_line_model (
	// clock and requests
	input wire logic i_clock,
	input wire logic i_fire,
	input wire logic [7:0] i_ring,
	input wire logic [7:0] i_loop,
	input wire logic i_ac,
	input wire logic i_oc,
	// converter side
	output lss_pkg::lss_sense_t o_sense
);
	initial o_sense = '0;
	always @(posedge i_clock) begin
		o_sense.sample_valid <= i_fire;
		// stale samples flip so an unqualified use shows up
		o_sense.ring_sample <= i_fire ? i_ring : ~o_sense.ring_sample;
		o_sense.loop_sample <= i_fire ? i_loop : ~o_sense.loop_sample;
		o_sense.ac_overload <= i_ac;
		o_sense.overcurrent <= i_oc;
		o_sense.offhook <= 1'b0;
	end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the line sensing block
// assumes lss_pkg and the line model are compiled first
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, ce, fire, ac, oc, hook, wake_seen, rd_p;
	logic offhook, barrier, wake, boost, cid, normal, irq;
	logic [7:0] ring, loop, rdata, th;
	logic [7:0] exp_q[$];
	int bad_count, checks, k;
	lss_pkg::lss_bus_t bus;
	lss_pkg::lss_sense_t sense;
	lss_core DUT (.i_clock(clk), .i_rst(rst), .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
		.i_sense(sense), .i_hook_request(hook), .o_offhook(offhook),
		.o_barrier_power(barrier), .o_wake(wake), .o_rx_boost(boost), .o_cid_mode(cid),
		.o_rx_normal_path(normal), .o_irq(irq));
	lss_line_model line (.i_clock(clk), .i_fire(fire), .i_ring(ring), .i_loop(loop),
		.i_ac(ac), .i_oc(oc), .o_sense(sense));
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(e);
		@(posedge clk);
		bus.rd <= 1'b0;
	endtask
	task sample(input logic [7:0] r, input logic [7:0] l, input logic e);
		int n;
		@(posedge clk);
		ring <= r;
		loop <= l;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wake_seen = 1'b0;
		for (n = 0; n < 6; n++) begin
			@(posedge clk);
			wake_seen |= wake;
		end
		chk(wake_seen, e);
	endtask
	task results;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		rd_p <= bus.rd;
		if (rd_p && exp_q.size() > 0)
			chk(rdata, exp_q.pop_front());
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		results;
	end
	initial begin
		{rst, bus, fire, ac, oc, hook, ring, bad_count, checks} = '0;
		rst = 1'b1;
		ce = 1'b1;
		loop = 8'h30;
		void'($urandom(70511));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'h31, 8'h00);
		rd(8'h32, 8'h01);
		rd(8'h7F, 8'h00);
		wr(8'h14, 8'h08);
		wr(8'h15, 8'h10);
		rd(8'h14, 8'h00);
		rd(8'h15, 8'h10);
		chk({boost, cid, normal}, 8'h06);
		wr(8'h30, 8'h01);
		sample(8'h7F, 8'h30, 1'b0);
		for (k = 1; k < 4; k++) begin
			th = 8'(k * 15);
			wr(8'h0E, 8'(k));
			sample(th, 8'h30, 1'b0);
			sample(th + 8'h01 + 8'($urandom % 8), 8'h30, 1'b1);
			chk(irq, 1'b1);
			rd(8'h31, 8'h01);
			rd(8'h31, 8'h00);
		end
		sample(8'h00, 8'hCF, 1'b1);
		wr(8'h32, 8'h00);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rd(8'h31, 8'h01);
		wr(8'h30, 8'h08);
		hook <= 1'b1;
		oc <= 1'b1;
		ac <= 1'b1;
		repeat (4) @(posedge clk);
		chk(offhook, 1'b1);
		wr(8'h30, 8'h09);
		repeat (3) @(posedge clk);
		chk(offhook, 1'b0);
		oc <= 1'b0;
		ac <= 1'b0;
		wr(8'h32, 8'h18);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rd(8'h31, 8'h18);
		wr(8'h33, 8'h18);
		rd(8'h31, 8'h00);
		chk(irq, 1'b0);
		wr(8'h30, 8'h23);
		sample(8'h00, 8'h05, 1'b0);
		chk(barrier, 1'b1);
		rd(8'h31, 8'h02);
		ce <= 1'b0;
		wr(8'h0E, 8'h01);
		ce <= 1'b1;
		rd(8'h0E, 8'h03);
		repeat (2) @(posedge clk);
		results;
	end
endmodule
